// >>> verification/can_command_status_logic_tb_top.sv
// self-checking bench for the command and status block
// assumes the engine stand-in answers each request within a few cycles
`timescale 1ns/1ps
module can_command_status_logic_tb_top
   import can_cmd_pkg::*;
;
   logic clock = 1'b0;
   logic srst = 1'b1;
   bus_req_s busReq = '0;
   logic [7:0] txErrCount = 8'h00, rxErrCount = 8'h00, rdata, d;
   logic busOffNow = 1'b0, receivingNow = 1'b0, rxFrameOk = 1'b0;
   logic hold = 1'b1, failMode = 1'b0;
   logic sendingNow, txOk, txFail, rxRelease, rxPending, txIrq, overrunIrq;
   tx_ctrl_s txCtrl;
   txbuf_wr_s txBufWr;
   int errTotal = 0, numChecks = 0, cycles = 0;
   int irqCnt = 0, ovrCnt = 0, relCnt = 0, weCnt = 0, failCnt = 0;
   logic [11:0] lastWr = '0;
   typedef struct packed { logic [7:0] cmd; logic [2:0] ctrl; } row_s;
   row_s rows [6] = '{'{8'h01, 3'b100}, '{8'h03, 3'b110}, '{8'h10, 3'b101},
      '{8'h12, 3'b111}, '{8'h13, 3'b110}, '{8'h11, 3'b100}};

   always #4 clock = ~clock;

   can_command_status_logic uut (.clock(clock), .srst(srst), .busReq(busReq),
      .rdata(rdata), .busOffNow(busOffNow), .sendingNow(sendingNow),
      .receivingNow(receivingNow), .txErrCount(txErrCount), .rxErrCount(rxErrCount),
      .txOk(txOk), .txFail(txFail), .rxFrameOk(rxFrameOk), .txCtrl(txCtrl),
      .txBufWr(txBufWr), .rxRelease(rxRelease), .rxPending(rxPending),
      .txIrq(txIrq), .overrunIrq(overrunIrq));

   can_engine_model engine (.clock(clock), .srst(srst), .hold(hold),
      .failMode(failMode), .txCtrl(txCtrl), .sendingNow(sendingNow),
      .txOk(txOk), .txFail(txFail));

   task automatic endOfTest();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : endOfTest

   // pulses are counted so no single-cycle event is missed
   always @(posedge clock)
   begin
      cycles++;
      irqCnt += int'(txIrq === 1'b1);
      ovrCnt += int'(overrunIrq === 1'b1);
      relCnt += int'(rxRelease === 1'b1);
      weCnt += int'(txBufWr.we === 1'b1);
      failCnt += int'(txFail === 1'b1);
      // buffer writes stand one cycle, so keep the last accepted one
      if (txBufWr.we === 1'b1)
      begin
         lastWr = {txBufWr.idx, txBufWr.data};
      end
      if (cycles == 20000)
      begin
         errTotal++;
         endOfTest();
      end
   end

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      numChecks++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         errTotal++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clock);
      busReq <= '0;
      @(posedge clock);
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock);
      busReq <= '0;
      #1;
      d = rdata;
      @(posedge clock);
      #1;
   endtask : rd

   task automatic waitCnt(ref int c, input int n);
      repeat (100)
         if (c < n)
            @(posedge clock);
      #1;
   endtask : waitCnt

   task automatic waitSend();
      repeat (50)
         if (sendingNow !== 1'b1)
            @(posedge clock);
      #1;
   endtask : waitSend

   initial
   begin
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      #1;
      rd(STATE_ADDR);
      chk("state", 8'h0c, d);
      rd(CMD_ADDR);
      chk("command", 8'h00, d);
      wr(STATE_ADDR, 8'hff);
      rd(STATE_ADDR);
      chk("state", 8'h0c, d);
      rd(8'h00);
      chk("unmapped", 8'h00, d);
      rd(WARN_ADDR);
      chk("warn limit", WARN_LIMIT_RESET, d);
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(CMD_ADDR, rows[i].cmd);
         chk("request", {5'h00, rows[i].ctrl}, {5'h00, txCtrl});
         rd(STATE_ADDR);
         chk("state", 8'h00, d);
         wr(CMD_ADDR, 8'h02);
         waitCnt(irqCnt, i + 1);
         chk("irqs", 8'(i + 1), 8'(irqCnt));
         chk("request", {6'h00, rows[i].ctrl[1:0]}, {5'h00, txCtrl});
      end
      $display("test combinations done");
      wr(CMD_ADDR, 8'h01);
      wr(TXBUF_FIRST, 8'h5a);
      wr(CMD_ADDR, 8'h00);
      chk("writes", 8'h00, 8'(weCnt));
      chk("request", 8'h04, {5'h00, txCtrl});
      hold <= 1'b0;
      waitSend();
      @(posedge clock);
      #1;
      chk("request", 8'h00, {5'h00, txCtrl});
      rd(STATE_ADDR);
      chk("state", 8'h20, d & 8'h2c);
      waitCnt(irqCnt, 7);
      rd(STATE_ADDR);
      chk("state", 8'h0c, d);
      wr(TXBUF_LAST, 8'ha5);
      chk("writes", 8'h01, 8'(weCnt));
      chk("buffer index", 8'h09, {4'h0, lastWr[11:8]});
      chk("buffer data", 8'ha5, lastWr[7:0]);
      $display("test send done");
      // abort arrives once the frame is already running
      wr(CMD_ADDR, 8'h01);
      waitSend();
      wr(CMD_ADDR, 8'h02);
      waitCnt(irqCnt, 8);
      rd(STATE_ADDR);
      chk("state", 8'h0c, d);
      failMode <= 1'b1;
      wr(CMD_ADDR, 8'h03);
      waitCnt(irqCnt, 9);
      chk("request", 8'h02, {5'h00, txCtrl});
      rd(STATE_ADDR);
      chk("state", 8'h04, d);
      wr(CMD_ADDR, 8'h01);
      waitCnt(failCnt, 2);
      failMode <= 1'b0;
      waitCnt(irqCnt, 10);
      chk("fails", 8'h02, 8'(failCnt));
      rd(STATE_ADDR);
      chk("state", 8'h0c, d);
      $display("test abort and retry done");
      receivingNow <= 1'b1;
      rd(STATE_ADDR);
      chk("state", 8'h1c, d);
      receivingNow <= 1'b0;
      // queue holds eight messages, the ninth and tenth are dropped
      repeat (10)
      begin
         rxFrameOk <= 1'b1;
         @(posedge clock);
         rxFrameOk <= 1'b0;
         @(posedge clock);
      end
      #1;
      rd(STATE_ADDR);
      chk("state", 8'h0f, d);
      chk("overruns", 8'h01, 8'(ovrCnt));
      wr(CMD_ADDR, 8'h08);
      rd(STATE_ADDR);
      chk("state", 8'h0d, d);
      repeat (7) wr(CMD_ADDR, 8'h04);
      chk("pending", 8'h01, {7'h00, rxPending});
      wr(CMD_ADDR, 8'h04);
      chk("releases", 8'h08, 8'(relCnt));
      chk("pending", 8'h00, {7'h00, rxPending});
      $display("test receive done");
      busOffNow <= 1'b1;
      txErrCount <= 8'h60;
      rxErrCount <= 8'h5f;
      @(posedge clock);
      rd(STATE_ADDR);
      chk("state", 8'hcc, d);
      busOffNow <= 1'b0;
      txErrCount <= 8'h5f;
      @(posedge clock);
      rd(STATE_ADDR);
      chk("state", 8'h0c, d);
      rxErrCount <= 8'h60;
      @(posedge clock);
      rd(STATE_ADDR);
      chk("state", 8'h4c, d);
      rxErrCount <= 8'h00;
      wr(WARN_ADDR, 8'h5f);
      rd(STATE_ADDR);
      chk("state", 8'h4c, d);
      rd(WARN_ADDR);
      chk("warn limit", 8'h5f, d);
      $display("test status done");
      endOfTest();
   end
endmodule : can_command_status_logic_tb_top

// >>> verification/can_engine_model.sv
// protocol engine stand-in facing the command and status block
// assumes the bench steers stalls and frame failures through hold and failMode
`timescale 1ns/1ps
module can_engine_model
   import can_cmd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // bench control
   input wire logic hold,
   input wire logic failMode,
   // block side
   input wire tx_ctrl_s txCtrl,
   output logic sendingNow,
   output logic txOk,
   output logic txFail
);
   logic [3:0] cnt;
   always_ff @(posedge clock)
   begin
      txOk <= 1'b0;
      txFail <= 1'b0;
      if (srst)
         sendingNow <= 1'b0;
      else if (!sendingNow && txCtrl.request && !hold)
      begin
         sendingNow <= 1'b1;
         cnt <= 4'h5;
      end
      else if (sendingNow)
      begin
         cnt <= cnt - 4'h1;
         // outcome pulses while the frame is still on the wire
         txOk <= (cnt == 4'h1) && !failMode;
         txFail <= (cnt == 4'h1) && failMode;
         sendingNow <= (cnt != 4'h0);
      end
   end
endmodule : can_engine_model

// >>> verilog/can_cmd_pkg.sv
// constants, field layout and carrier types of the command and status block
// assumes one 125 MHz clock shared by the host port and the protocol engine
package can_cmd_pkg;

   // register offsets on the 8-bit host port
   localparam logic [7:0] CMD_ADDR = 8'h01;
   localparam logic [7:0] STATE_ADDR = 8'h02;
   localparam logic [7:0] WARN_ADDR = 8'h06;
   localparam logic [7:0] TXBUF_FIRST = 8'h0a;
   localparam logic [7:0] TXBUF_LAST = 8'h13;

   // command_reg bit positions
   localparam int CMD_SEND = 0;
   localparam int CMD_ABORT = 1;
   localparam int CMD_RELEASE = 2;
   localparam int CMD_OVR_CLR = 3;
   localparam int CMD_LOOP = 4;

   // reset values and queue size
   localparam logic [7:0] WARN_LIMIT_RESET = 8'h60;
   localparam logic DONE_RESET = 1'b1;
   localparam int RXQ_W = 4;
   localparam logic [RXQ_W-1:0] RXQ_DEPTH = 4'h8;

   typedef enum logic [1:0] {TX_FREE, TX_WAITING, TX_ACTIVE} tx_state_e;

   // host register port, one strobe per cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bus_req_s;

   // request towards the bit stream engine
   typedef struct packed {
      logic request;
      logic singleShot;
      logic selfRx;
   } tx_ctrl_s;

   // accepted write into the transmit buffer
   typedef struct packed {
      logic we;
      logic [3:0] idx;
      logic [7:0] data;
   } txbuf_wr_s;

   typedef struct packed {
      tx_state_e txState;
      tx_ctrl_s txCtrl;
      logic doneFlag;
      logic overrunFlag;
      logic [RXQ_W-1:0] rxCount;
      logic rxPending;
      logic [7:0] warnLimit;
      logic warnFlag;
      logic sendingPrev;
      logic [7:0] readData;
      logic txIrq;
      logic overrunIrq;
      logic rxRelease;
      txbuf_wr_s txBufWr;
   } ctrl_state_s;

   localparam ctrl_state_s ST_RESET = '{
      txState: TX_FREE,
      txCtrl: '0,
      doneFlag: DONE_RESET,
      overrunFlag: 1'b0,
      rxCount: '0,
      rxPending: 1'b0,
      warnLimit: WARN_LIMIT_RESET,
      warnFlag: 1'b0,
      sendingPrev: 1'b0,
      readData: '0,
      txIrq: 1'b0,
      overrunIrq: 1'b0,
      rxRelease: 1'b0,
      txBufWr: '0
   };

endpackage : can_cmd_pkg

// >>> verilog/can_command_status_logic.sv
// command decode and status reporting of a stand-alone CAN controller
// assumes the protocol engine runs on the same clock and pulses its events
// Contract
// - command register always reads back zero
// - loopback request sends and self-receives message
// - overrun clear command clears overrun flag
// - no overrun interrupt while flag set
// - release frees queue slot, pending follows
// - cancel withdraws waiting request, not running
// - send request queued, zero write ignored
// - send plus cancel means single shot
// - loopback plus cancel is single-shot loopback
// - all three behave as send plus cancel
// - send plus loopback ignores loopback
// - request clears when sending starts
// - transmit interrupt also on abort
// - state register read-only, bit7 offline
// - bit6 set when counter reaches limit
// - bit5 sending, bit4 receiving
// - bit3 set after successful send
// - bit2 set when buffer is free
// - send or loopback write clears done
// - writes to locked buffer silently dropped
// - full queue drops good frame, sets overrun
`timescale 1ns/1ps
module can_command_status_logic
   import can_cmd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // host register port
   input wire bus_req_s busReq,
   output logic [7:0] rdata,
   // protocol engine status
   input wire logic busOffNow,
   input wire logic sendingNow,
   input wire logic receivingNow,
   input wire logic [7:0] txErrCount,
   input wire logic [7:0] rxErrCount,
   // protocol engine events
   input wire logic txOk,
   input wire logic txFail,
   input wire logic rxFrameOk,
   // towards the protocol engine and buffers
   output tx_ctrl_s txCtrl,
   output txbuf_wr_s txBufWr,
   output logic rxRelease,
   output logic rxPending,
   // event pulses for the interrupt logic
   output logic txIrq,
   output logic overrunIrq
);

   ctrl_state_s stReg;
   ctrl_state_s stNext;
   logic cmdWrite;
   logic sendCmd;
   logic abortCmd;
   logic releaseCmd;
   logic clearCmd;
   logic loopCmd;
   logic startCmd;
   logic releaseOk;
   logic rxFull;
   logic rxStore;
   logic rxDrop;
   logic sendingRise;
   logic bufWrite;
   logic [7:0] statusWord;

   assign cmdWrite = busReq.wr && busReq.addr == CMD_ADDR;
   assign sendCmd = cmdWrite && busReq.wdata[CMD_SEND];
   assign abortCmd = cmdWrite && busReq.wdata[CMD_ABORT];
   assign releaseCmd = cmdWrite && busReq.wdata[CMD_RELEASE];
   assign clearCmd = cmdWrite && busReq.wdata[CMD_OVR_CLR];
   assign loopCmd = cmdWrite && busReq.wdata[CMD_LOOP];
   assign startCmd = sendCmd || loopCmd;
   assign releaseOk = releaseCmd && stReg.rxCount != '0;
   assign rxFull = stReg.rxCount == RXQ_DEPTH;
   assign rxStore = rxFrameOk && !rxFull;
   assign rxDrop = rxFrameOk && rxFull;
   assign sendingRise = sendingNow && !stReg.sendingPrev;
   assign bufWrite = busReq.wr && busReq.addr >= TXBUF_FIRST
      && busReq.addr <= TXBUF_LAST;

   // status word, live inputs sampled at the read
   // activity bits straight from the engine
   // buffer free whenever nothing is queued or sent
   assign statusWord = {busOffNow, stReg.warnFlag, sendingNow, receivingNow,
      stReg.doneFlag, stReg.txState == TX_FREE, stReg.overrunFlag, stReg.rxPending};

   always_comb
   begin
      stNext = stReg;
      stNext.txIrq = 1'b0;
      stNext.overrunIrq = 1'b0;
      stNext.sendingPrev = sendingNow;
      stNext.rxRelease = releaseCmd;

      // any send or loopback write clears done except in the cycle of txOk
      if (startCmd)
      begin
         stNext.doneFlag = 1'b0;
      end

      unique case (stReg.txState)
         TX_FREE:
         begin
            // a one queues the message, zeros are ignored
            if (startCmd)
            begin
               stNext.txState = TX_WAITING;
               // cancel beside a start means single shot
               stNext.txCtrl.singleShot = abortCmd;
               // so all three give single-shot send
               // loopback alone asks for self reception
               stNext.txCtrl.selfRx = loopCmd && !sendCmd;
            end
         end
         TX_WAITING:
         begin
            // an abort on the start edge loses: the frame is already on the wire
            // request drops as sending starts
            if (sendingRise)
            begin
               stNext.txState = TX_ACTIVE;
            end
            // cancel only before the frame starts
            else if (abortCmd)
            begin
               stNext.txState = TX_FREE;
               // abort frees the buffer and interrupts
               stNext.txIrq = 1'b1;
            end
         end
         TX_ACTIVE:
         begin
            // success marks done and frees the buffer
            if (txOk)
            begin
               stNext.txState = TX_FREE;
               stNext.doneFlag = 1'b1;
               stNext.txIrq = 1'b1;
            end
            else if (txFail)
            begin
               if (stReg.txCtrl.singleShot)
               begin
                  stNext.txState = TX_FREE;
                  stNext.txIrq = 1'b1;
               end
               else
               begin
                  stNext.txState = TX_WAITING;
               end
            end
         end
      endcase
      stNext.txCtrl.request = stNext.txState == TX_WAITING;
      // attributes stay from the last start; the engine reads them only with request

      // locked buffer drops the byte with no trace
      stNext.txBufWr.we = bufWrite && stReg.txState == TX_FREE;
      stNext.txBufWr.idx = 4'(busReq.addr - TXBUF_FIRST);
      stNext.txBufWr.data = busReq.wdata;

      // release and store in one cycle cancel out
      if (rxStore && !releaseOk)
      begin
         stNext.rxCount = stReg.rxCount + 4'h1;
      end
      else if (releaseOk && !rxStore)
      begin
         stNext.rxCount = stReg.rxCount - 4'h1;
      end
      stNext.rxPending = stNext.rxCount != '0;

      // clear acts, but a new overrun wins over it
      if (clearCmd)
      begin
         stNext.overrunFlag = 1'b0;
      end
      if (rxDrop)
      begin
         stNext.overrunFlag = 1'b1;
         // no repeat interrupt while still set
         stNext.overrunIrq = !stReg.overrunFlag;
      end

      stNext.warnFlag = txErrCount >= stReg.warnLimit || rxErrCount >= stReg.warnLimit;
      if (busReq.wr && busReq.addr == WARN_ADDR)
      begin
         stNext.warnLimit = busReq.wdata;
      end

      // command register and holes read as zero
      stNext.readData = 8'h00;
      if (busReq.rd)
      begin
         if (busReq.addr == STATE_ADDR)
         begin
            stNext.readData = statusWord;
         end
         else if (busReq.addr == WARN_ADDR)
         begin
            stNext.readData = stReg.warnLimit;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         stReg <= ST_RESET;
      end
      else
      begin
         stReg <= stNext;
      end
   end

   assign rdata = stReg.readData;
   assign txCtrl = stReg.txCtrl;
   assign txBufWr = stReg.txBufWr;
   assign rxRelease = stReg.rxRelease;
   assign rxPending = stReg.rxPending;
   assign txIrq = stReg.txIrq;
   assign overrunIrq = stReg.overrunIrq;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   sequence seqWaiting;
      stReg.txState == TX_WAITING;
   endsequence

   sequence seqFreed;
      stReg.txState == TX_FREE && txIrq;
   endsequence

   sequence seqSingleStart;
      stReg.txState == TX_FREE && sendCmd && abortCmd;
   endsequence

   chk_cmd_read_zero: assert property (busReq.rd && busReq.addr == CMD_ADDR |=> rdata == 8'h00)
      else $error("command register read back nonzero");

   chk_overrun_clear: assert property (clearCmd && !rxDrop |=> !stReg.overrunFlag)
      else $error("overrun flag survived clear");

   chk_overrun_irq_once: assert property (rxDrop && stReg.overrunFlag |=> !overrunIrq)
      else $error("overrun interrupt while flag set");

   chk_release_count: assert property (releaseOk && !rxStore
      |=> stReg.rxCount == $past(stReg.rxCount) - 4'h1 && rxPending == (stReg.rxCount != '0))
      else $error("release did not free a queue slot");

   chk_abort_waiting: assert property (seqWaiting ##0 abortCmd && !startCmd && !sendingRise
      |=> seqFreed)
      else $error("waiting request not withdrawn");

   chk_active_kept: assert property (stReg.txState == TX_ACTIVE && abortCmd && !txOk && !txFail
      |=> stReg.txState == TX_ACTIVE)
      else $error("abort stopped a running frame");

   chk_send_taken: assert property (stReg.txState == TX_FREE && sendCmd
      |=> txCtrl.request && !stReg.doneFlag ##1 txCtrl.request || stReg.txState != TX_WAITING)
      else $error("send request not held");

   chk_single_setup: assert property (seqSingleStart
      |=> seqWaiting ##0 txCtrl.singleShot)
      else $error("single-shot attribute not set");

   chk_single_shot: assert property (stReg.txState == TX_ACTIVE && txFail && !txOk
      && stReg.txCtrl.singleShot |=> seqFreed)
      else $error("single-shot frame retried");

   chk_loop_ignored: assert property (stReg.txState == TX_FREE && sendCmd && loopCmd
      |=> !txCtrl.selfRx && txCtrl.singleShot == $past(abortCmd))
      else $error("loopback honoured beside send");

   chk_loop_single: assert property (stReg.txState == TX_FREE && loopCmd && abortCmd && !sendCmd
      |=> txCtrl.selfRx && txCtrl.singleShot)
      else $error("single-shot loopback not set up");

   chk_req_drops: assert property (seqWaiting ##0 sendingRise |=> !txCtrl.request)
      else $error("request held after sending began");

   chk_done_set: assert property (stReg.txState == TX_ACTIVE && txOk
      |=> seqFreed ##0 stReg.doneFlag)
      else $error("success did not mark done");

   chk_status_read: assert property (busReq.rd && busReq.addr == STATE_ADDR
      |=> rdata[7] == $past(busOffNow) && rdata[5] == $past(sendingNow)
      && rdata[4] == $past(receivingNow))
      else $error("status bits do not match engine");

   chk_warn_flag: assert property (txErrCount >= stReg.warnLimit |=> stReg.warnFlag)
      else $error("warning flag missed limit");

   chk_locked_drop: assert property (bufWrite && stReg.txState != TX_FREE |=> !txBufWr.we)
      else $error("write into locked buffer accepted");

   chk_overrun_set: assert property (rxDrop |=> stReg.overrunFlag
      && stReg.rxCount == $past(stReg.rxCount) - {3'h0, $past(releaseOk)})
      else $error("full queue did not raise overrun");

   chk_release_pulse: assert property (cmdWrite |=> rxRelease == $past(busReq.wdata[CMD_RELEASE]))
      else $error("release pulse mismatch");

   chk_loop_self: assert property (stReg.txState == TX_FREE && loopCmd && !sendCmd
      |=> txCtrl.request && txCtrl.selfRx)
      else $error("loopback request not set up");

   chk_retry: assert property (stReg.txState == TX_ACTIVE && txFail && !txOk
      && !stReg.txCtrl.singleShot |=> seqWaiting ##0 txCtrl.request)
      else $error("failed frame not requested again");

   chk_done_cleared: assert property (startCmd && !(stReg.txState == TX_ACTIVE && txOk)
      |=> !stReg.doneFlag)
      else $error("start left done flag set");

   chk_free_bit: assert property (busReq.rd && busReq.addr == STATE_ADDR
      && stReg.txState != TX_FREE |=> !rdata[2])
      else $error("buffer shown free while locked");

   chk_warn_clear: assert property (txErrCount < stReg.warnLimit
      && rxErrCount < stReg.warnLimit |=> !stReg.warnFlag)
      else $error("warning flag set below limit");

   chk_buffer_take: assert property (bufWrite && stReg.txState == TX_FREE
      |=> txBufWr.we && txBufWr.data == $past(busReq.wdata))
      else $error("write into free buffer lost");

   // read data only after a read
   chk_read_idle: assert property (!busReq.rd |=> rdata == 8'h00)
      else $error("read data outside a read");

endmodule : can_command_status_logic
